// ===== swu_consts.svh
// Constants shared by both ends of the single wire link
`ifndef SWU_CONSTS_SVH
`define SWU_CONSTS_SVH
`define SWU_CLK_HZ          32'h02FAF080
`define SWU_MIN_BAUD        32'h00002328
`define SWU_MIN_DIV         16'h0010
`define SWU_HOST_DIV_DEF    16'h01B2
`define SWU_SYNC_BYTE       8'h05
`define SWU_SYNC_PRELOAD    8'hA0
`define SWU_MASTER_ADDR     8'hFF
`define SWU_WRITE_BIT       7
`define SWU_CRC_POLY        8'h07
`define SWU_GLITCH_CLKS     24'h000010
`define SWU_PAUSE_BITS      24'h00003F
`define SWU_RECOVER_BITS    24'h00000C
`define SWU_DELAY_STEP_BITS 7'h08
`define SWU_TAIL_BITS       4'h4
`define SWU_HOST_WAIT_BITS  8'hFF
`define SWU_BT_RESET        16'h0010
`define SWU_RD_LAST         4'h3
`define SWU_WR_LAST         4'h7
`define SWU_TAIL_IDX        4'h8
`define SWU_STOP_POS        4'h9
`define SWU_WAIT_POS        4'hA
`define SWU_SYNC_RESUME_POS 4'h4
`endif

// ===== swu_pkg.sv
// Types and the CRC step shared by both ends of the single wire link
`include "swu_consts.svh"
package swu_pkg;
   typedef enum logic [5:0] {
      SWD_IDLE    = 6'h01,
      SWD_MEAS    = 6'h02,
      SWD_RX      = 6'h04,
      SWD_RECOVER = 6'h08,
      SWD_WAIT    = 6'h10,
      SWD_TX      = 6'h20
   } swu_dev_state_type;

   typedef enum logic [3:0] {
      SWH_IDLE = 4'h1,
      SWH_GAP  = 4'h2,
      SWH_TX   = 4'h4,
      SWH_RX   = 4'h8
   } swu_host_state_type;

   typedef struct packed {
      swu_dev_state_type st;
      logic [1:0]        sync_line;
      logic [1:0]        sync_inc;
      logic              line_prev;
      logic [15:0]       bt;
      logic [15:0]       good_bt;
      logic [23:0]       ph;
      logic [23:0]       gap;
      logic              edges;
      logic [3:0]        bitpos;
      logic [3:0]        bidx;
      logic [7:0]        sh;
      logic [7:0]        crc;
      logic [7:0]        addr;
      logic [7:0]        regb;
      logic [31:0]       data;
      logic [63:0]       tx;
      logic [7:0]        cnt;
      logic              wr_valid;
      logic              rd_req;
      logic              out;
      logic              oe_n;
   } swu_dev_type;

   typedef struct packed {
      swu_host_state_type st;
      logic [1:0]         sync_line;
      logic               line_prev;
      logic [15:0]        ph;
      logic [7:0]         cnt;
      logic [3:0]         bitpos;
      logic [3:0]         bidx;
      logic [3:0]         last;
      logic [63:0]        tx;
      logic [7:0]         sh;
      logic [7:0]         crc;
      logic [31:0]        data;
      logic               ready;
      logic               rsp_valid;
      logic               rsp_err;
      logic               out;
      logic               oe_n;
   } swu_host_type;

   // One byte through the CRC, least significant bit first
   function automatic logic [7:0] swu_crc_byte(input logic [7:0] crc_in,
                                               input logic [7:0] data_in);
      logic [7:0] c;
      logic [7:0] b;
      c = crc_in;
      b = data_in;
      for (int i = 0; i < 8; i++) begin
         if (c[7] ^ b[0]) begin
            c = {c[6:0], 1'b0} ^ `SWU_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
         b = {1'b0, b[7:1]};
      end
      return c;
   endfunction
endpackage

// ===== swu_link_if.sv
// Shared single data line between host and device
`timescale 1ns/10ps
`default_nettype none
interface swu_link_if;
   logic dev_out;
   logic dev_oe_n;
   logic host_out;
   logic host_oe_n;
   logic line;

   // Idle line is pulled high; any enabled driver sending low pulls it down
   assign line = (dev_oe_n | dev_out) & (host_oe_n | host_out);

   modport dev  (output dev_out, output dev_oe_n, input line);
   modport host (output host_out, output host_oe_n, input line);
endinterface
`default_nettype wire

// ===== swu_device.sv
// Device end of the single wire UART: auto-baud receiver, addressing and reply sender
// How it works
// - Write datagram: sync, address, register, data, CRC
// - Sync nibble first, address byte follows
// - Bit time remeasured on every incoming transmission
// - Bytes framed by low start, high stop
// - Bit time: start edge to bit3 edge, /4
// - Data word sent high byte first
// - Host baud between 9000 and clock/16
// - Own address is setting plus increment pin
// - Over 63 bit times between starts resets
// - Host waits 12 idle bit times afterwards
// - Pulse under 16 clocks: glitch, 12-bit idle
// - CRC or framing error discards, same recovery
// - Host never drops baud below 15 percent
// - Accepted writes bump wrapping 8-bit counter
// - Read requests leave the counter alone
// - CRC x^8+x^2+x+1 from zero, LSB first
// - Act only on good CRC and own address
// - Reply after setting (0 taken as 1) times eight bit times
`timescale 1ns/10ps
`default_nettype none
`include "swu_consts.svh"
module swu_device import swu_pkg::*; (
   input  wire logic        clock,
   input  wire logic        resetn,
   swu_link_if.dev          link,
   input  wire logic [7:0]  node_address_setting,
   input  wire logic        address_increment_pin,
   input  wire logic [3:0]  reply_delay_setting,
   input  wire logic [31:0] rd_data,
   output logic             wr_valid,
   output logic [6:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic             rd_req,
   output logic [6:0]       rd_addr,
   output logic [7:0]       datagram_count
);
   localparam swu_dev_type DEV_RST = '{st: SWD_IDLE, sync_line: 2'h3, line_prev: 1'b1,
                                       bt: `SWU_BT_RESET, good_bt: `SWU_BT_RESET,
                                       out: 1'b1, oe_n: 1'b1, default: '0};

   swu_dev_type q;
   swu_dev_type d;
   logic        ln;
   logic        fall;
   logic        rise;
   logic        half_hit;
   logic        end_hit;
   logic        is_last;
   logic [7:0]  own_addr;
   logic [23:0] meas_len;
   logic [23:0] pause_lim;
   logic [23:0] recover_lim;
   logic [3:0]  delay_steps;
   logic [6:0]  delay_bits;
   logic [63:0] reply;
   logic [7:0]  reply_crc;
   logic [7:0]  txb;
   logic [2:0]  bsel;

   always_comb begin
      ln = q.sync_line[1];
      fall = q.line_prev & ~ln;
      rise = ~q.line_prev & ln;
      own_addr = node_address_setting + {7'h00, q.sync_inc[1]};
      half_hit = (q.ph == {9'h000, q.bt[15:1]});
      end_hit = (q.ph == {8'h00, q.bt - 16'h0001});
      meas_len = q.ph + 24'h000001;
      pause_lim = 24'(q.good_bt) * `SWU_PAUSE_BITS;
      recover_lim = 24'(q.bt) * `SWU_RECOVER_BITS;
      is_last = ((q.bidx == `SWU_RD_LAST) && !q.regb[`SWU_WRITE_BIT])
                || (q.bidx == `SWU_WR_LAST);
      delay_steps = (reply_delay_setting == 4'h0) ? 4'h1 : reply_delay_setting;
      delay_bits = 7'(delay_steps) * `SWU_DELAY_STEP_BITS;
      reply = {`SWU_SYNC_BYTE, `SWU_MASTER_ADDR, 1'b0, q.regb[6:0], rd_data, 8'h00};
      reply_crc = 8'h00;
      for (int i = 0; i < 7; i++) begin
         reply_crc = swu_crc_byte(reply_crc, reply[63 - 8 * i -: 8]);
      end

      d = q;
      d.sync_line = {q.sync_line[0], link.line};
      d.sync_inc = {q.sync_inc[0], address_increment_pin};
      d.line_prev = ln;
      d.wr_valid = 1'b0;
      d.rd_req = 1'b0;
      d.ph = q.ph + 24'h000001;

      unique case (q.st)
         SWD_IDLE: begin
            d.ph = '0;
            if (fall) begin
               d.st = SWD_MEAS;
               d.edges = 1'b0;
            end
         end
         SWD_MEAS: begin
            // Low time counts the detecting cycle, so a full 16-clock bit passes
            if (rise && !q.edges && (meas_len < `SWU_GLITCH_CLKS)) begin
               d.st = SWD_RECOVER;
               d.ph = '0;
            end else if (fall) begin
               if (!q.edges) begin
                  d.edges = 1'b1;
               end else begin
                  // Third falling edge closes four bit periods
                  d.bt = meas_len[17:2];
                  d.st = SWD_RX;
                  d.bitpos = `SWU_SYNC_RESUME_POS;
                  d.ph = '0;
                  d.gap = meas_len;
                  d.sh = `SWU_SYNC_PRELOAD;
                  d.bidx = 4'h0;
                  d.crc = 8'h00;
               end
            end else if (&q.ph) begin
               d.st = SWD_RECOVER;
               d.ph = '0;
            end
         end
         SWD_RX: begin
            d.gap = q.gap + 24'h000001;
            if (q.gap > pause_lim) begin
               d.st = SWD_RECOVER;
               d.ph = '0;
            end else if (q.bitpos == `SWU_WAIT_POS) begin
               if (fall) begin
                  d.bitpos = 4'h0;
                  d.ph = '0;
                  d.gap = '0;
               end
            end else begin
               if (end_hit && (q.bitpos != `SWU_STOP_POS)) begin
                  d.ph = '0;
                  d.bitpos = q.bitpos + 4'h1;
               end
               if (half_hit) begin
                  if (q.bitpos == 4'h0) begin
                     if (ln) begin
                        d.st = SWD_RECOVER;
                        d.ph = '0;
                     end
                  end else if (q.bitpos == `SWU_STOP_POS) begin
                     d.bitpos = `SWU_WAIT_POS;
                     if (!ln) begin
                        d.st = SWD_RECOVER;
                        d.ph = '0;
                     end else if (!is_last) begin
                        d.crc = swu_crc_byte(q.crc, q.sh);
                        d.bidx = q.bidx + 4'h1;
                        if (q.bidx == 4'h1) begin
                           d.addr = q.sh;
                        end else if (q.bidx == 4'h2) begin
                           d.regb = q.sh;
                        end else if (q.bidx != 4'h0) begin
                           d.data = {q.data[23:0], q.sh};
                        end
                     end else if (q.sh != q.crc) begin
                        d.st = SWD_RECOVER;
                        d.ph = '0;
                     end else if (q.addr == own_addr) begin
                        d.good_bt = q.bt;
                        if (q.regb[`SWU_WRITE_BIT]) begin
                           d.wr_valid = 1'b1;
                           d.cnt = q.cnt + 8'h01;
                           d.st = SWD_IDLE;
                        end else begin
                           d.rd_req = 1'b1;
                           d.st = SWD_WAIT;
                           d.ph = '0;
                           d.gap = '0;
                        end
                     end else begin
                        d.st = SWD_IDLE;
                     end
                  end else begin
                     d.sh = {ln, q.sh[7:1]};
                  end
               end
            end
         end
         SWD_RECOVER: begin
            if (!ln) begin
               d.ph = '0;
            end else if (q.ph >= recover_lim) begin
               d.st = SWD_IDLE;
            end
         end
         SWD_WAIT: begin
            if (end_hit) begin
               d.ph = '0;
               d.gap = q.gap + 24'h000001;
               if (q.gap == {17'h00000, delay_bits - 7'h01}) begin
                  d.tx = {reply[63:8], reply_crc};
                  d.st = SWD_TX;
                  d.bidx = 4'h0;
                  d.bitpos = 4'h0;
               end
            end
         end
         SWD_TX: begin
            if (end_hit) begin
               d.ph = '0;
               if (q.bidx == `SWU_TAIL_IDX) begin
                  // Keep driving high a few bit times before letting go
                  if (q.bitpos == `SWU_TAIL_BITS - 4'h1) begin
                     d.st = SWD_IDLE;
                  end else begin
                     d.bitpos = q.bitpos + 4'h1;
                  end
               end else if (q.bitpos == `SWU_STOP_POS) begin
                  d.bitpos = 4'h0;
                  d.bidx = q.bidx + 4'h1;
                  d.tx = {q.tx[55:0], 8'h00};
               end else begin
                  d.bitpos = q.bitpos + 4'h1;
               end
            end
         end
         default: begin
            d.st = SWD_IDLE;
         end
      endcase

      txb = d.tx[63:56];
      bsel = 3'(d.bitpos - 4'h1);
      d.oe_n = (d.st != SWD_TX);
      if (d.st != SWD_TX || d.bidx == `SWU_TAIL_IDX || d.bitpos == `SWU_STOP_POS) begin
         d.out = 1'b1;
      end else if (d.bitpos == 4'h0) begin
         d.out = 1'b0;
      end else begin
         d.out = txb[bsel];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   assign wr_valid = q.wr_valid;
   assign wr_addr = q.regb[6:0];
   assign wr_data = q.data;
   assign rd_req = q.rd_req;
   assign rd_addr = q.regb[6:0];
   assign datagram_count = q.cnt;
   assign link.dev_out = q.out;
   assign link.dev_oe_n = q.oe_n;
endmodule
`default_nettype wire

// ===== swu_host.sv
// Host end of the single wire UART: sends datagrams and collects read replies
`timescale 1ns/10ps
`default_nettype none
`include "swu_consts.svh"
module swu_host import swu_pkg::*; #(
   parameter logic [15:0] CLKS_PER_BIT = `SWU_HOST_DIV_DEF
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   swu_link_if.host         link,
   input  wire logic        cmd_valid,
   input  wire logic        cmd_write,
   input  wire logic [7:0]  cmd_slave,
   input  wire logic [6:0]  cmd_reg,
   input  wire logic [31:0] cmd_data,
   output logic             cmd_ready,
   output logic             rsp_valid,
   output logic             rsp_err,
   output logic [31:0]      rsp_data
);
   localparam logic [15:0] MAX_DIV = 16'(`SWU_CLK_HZ / `SWU_MIN_BAUD);
   // Divider held inside the range the device can follow, fixed for the whole run
   localparam logic [15:0] DIV = (CLKS_PER_BIT < `SWU_MIN_DIV) ? `SWU_MIN_DIV :
                                 ((CLKS_PER_BIT > MAX_DIV) ? MAX_DIV : CLKS_PER_BIT);
   localparam swu_host_type HOST_RST = '{st: SWH_IDLE, sync_line: 2'h3, line_prev: 1'b1,
                                         out: 1'b1, oe_n: 1'b1, default: '0};

   swu_host_type q;
   swu_host_type d;
   logic         ln;
   logic         fall;
   logic         half_hit;
   logic         end_hit;
   logic [55:0]  body;
   logic [7:0]   cmd_crc;
   logic [7:0]   txb;
   logic [2:0]   bsel;

   always_comb begin
      ln = q.sync_line[1];
      fall = q.line_prev & ~ln;
      half_hit = (q.ph == {1'b0, DIV[15:1]});
      end_hit = (q.ph == DIV - 16'h0001);
      body = {`SWU_SYNC_BYTE, cmd_slave, cmd_write, cmd_reg, cmd_data};
      cmd_crc = 8'h00;
      for (int i = 0; i < 7; i++) begin
         if (cmd_write || i < 3) begin
            cmd_crc = swu_crc_byte(cmd_crc, body[55 - 8 * i -: 8]);
         end
      end

      d = q;
      d.sync_line = {q.sync_line[0], link.line};
      d.line_prev = ln;
      d.rsp_valid = 1'b0;
      d.ph = q.ph + 16'h0001;

      unique case (q.st)
         SWH_IDLE: begin
            if (cmd_valid) begin
               d.st = SWH_GAP;
               d.ph = '0;
               d.cnt = '0;
               d.last = cmd_write ? `SWU_WR_LAST : `SWU_RD_LAST;
               d.tx = cmd_write ? {body, cmd_crc} : {body[55:32], cmd_crc, 32'h00000000};
            end
         end
         SWH_GAP: begin
            if (!ln) begin
               d.ph = '0;
               d.cnt = '0;
            end else if (end_hit) begin
               d.ph = '0;
               d.cnt = q.cnt + 8'h01;
               if (q.cnt == 8'(`SWU_RECOVER_BITS) - 8'h01) begin
                  d.st = SWH_TX;
                  d.bidx = 4'h0;
                  d.bitpos = 4'h0;
               end
            end
         end
         SWH_TX: begin
            if (end_hit) begin
               d.ph = '0;
               if (q.bitpos != `SWU_STOP_POS) begin
                  d.bitpos = q.bitpos + 4'h1;
               end else if (q.bidx != q.last) begin
                  d.bitpos = 4'h0;
                  d.bidx = q.bidx + 4'h1;
                  d.tx = {q.tx[55:0], 8'h00};
               end else if (q.last == `SWU_WR_LAST) begin
                  d.st = SWH_IDLE;
                  d.rsp_valid = 1'b1;
                  d.rsp_err = 1'b0;
               end else begin
                  d.st = SWH_RX;
                  d.bitpos = `SWU_WAIT_POS;
                  d.bidx = 4'h0;
                  d.cnt = '0;
                  d.crc = 8'h00;
               end
            end
         end
         SWH_RX: begin
            if (q.bitpos == `SWU_WAIT_POS) begin
               if (fall) begin
                  d.bitpos = 4'h0;
                  d.ph = '0;
                  d.cnt = '0;
               end else if (end_hit) begin
                  d.ph = '0;
                  d.cnt = q.cnt + 8'h01;
                  if (q.cnt == `SWU_HOST_WAIT_BITS) begin
                     d.st = SWH_IDLE;
                     d.rsp_valid = 1'b1;
                     d.rsp_err = 1'b1;
                  end
               end
            end else begin
               if (end_hit && (q.bitpos != `SWU_STOP_POS)) begin
                  d.ph = '0;
                  d.bitpos = q.bitpos + 4'h1;
               end
               if (half_hit) begin
                  if ((q.bitpos == 4'h0 && ln) || (q.bitpos == `SWU_STOP_POS && !ln)) begin
                     d.st = SWH_IDLE;
                     d.rsp_valid = 1'b1;
                     d.rsp_err = 1'b1;
                  end else if (q.bitpos == `SWU_STOP_POS) begin
                     d.bitpos = `SWU_WAIT_POS;
                     if (q.bidx != `SWU_WR_LAST) begin
                        d.crc = swu_crc_byte(q.crc, q.sh);
                        d.bidx = q.bidx + 4'h1;
                        if (q.bidx >= 4'h3) begin
                           d.data = {q.data[23:0], q.sh};
                        end
                     end else begin
                        d.st = SWH_IDLE;
                        d.rsp_valid = 1'b1;
                        d.rsp_err = (q.sh != q.crc);
                     end
                  end else if (q.bitpos != 4'h0) begin
                     d.sh = {ln, q.sh[7:1]};
                  end
               end
            end
         end
         default: begin
            d.st = SWH_IDLE;
         end
      endcase

      txb = d.tx[63:56];
      bsel = 3'(d.bitpos - 4'h1);
      d.ready = (d.st == SWH_IDLE);
      d.oe_n = (d.st != SWH_TX);
      if (d.st != SWH_TX || d.bitpos == `SWU_STOP_POS) begin
         d.out = 1'b1;
      end else if (d.bitpos == 4'h0) begin
         d.out = 1'b0;
      end else begin
         d.out = txb[bsel];
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q <= HOST_RST;
      end else begin
         q <= d;
      end
   end

   assign cmd_ready = q.ready;
   assign rsp_valid = q.rsp_valid;
   assign rsp_err = q.rsp_err;
   assign rsp_data = q.data;
   assign link.host_out = q.out;
   assign link.host_oe_n = q.oe_n;
endmodule
`default_nettype wire

// ===== swu_link_asserts.sv
// Checker for the shared line between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module swu_link_asserts (
   input wire logic clock,
   input wire logic resetn,
   input wire logic dev_out,
   input wire logic dev_oe_n,
   input wire logic host_out,
   input wire logic host_oe_n,
   input wire logic line
);
   logic [15:0] idle_q;
   logic [15:0] rel_q;
   logic [15:0] hdrv_q;
   logic [15:0] ddrv_q;
   logic [15:0] dhigh_q;

   // Run lengths: idle line, time since host release, drive time, final high stretch
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         idle_q  <= 16'h0000;
         rel_q   <= 16'h0000;
         hdrv_q  <= 16'h0000;
         ddrv_q  <= 16'h0000;
         dhigh_q <= 16'h0000;
      end else begin
         idle_q  <= !line ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hFFFF};
         rel_q   <= !host_oe_n ? 16'h0000 : rel_q + {15'h0000, rel_q != 16'hFFFF};
         hdrv_q  <= host_oe_n ? 16'h0000 : hdrv_q + 16'h0001;
         ddrv_q  <= dev_oe_n ? 16'h0000 : ddrv_q + 16'h0001;
         dhigh_q <= (dev_oe_n || !dev_out) ? 16'h0000 : dhigh_q + 16'h0001;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   one_driver_a: assert property (host_oe_n || dev_oe_n)
      else $error("both ends drive the line");
   host_sync_a: assert property ($fell(host_oe_n) |-> ##8 !host_out ##16 host_out
      ##16 !host_out ##16 host_out ##16 !host_out) else $error("host sync nibble wrong");
   dev_sync_a: assert property ($fell(dev_oe_n) |-> ##8 !dev_out ##16 dev_out
      ##16 !dev_out ##16 dev_out ##16 !dev_out) else $error("reply sync nibble wrong");
   host_stop_a: assert property ($fell(host_oe_n) |-> ##152 host_out ##16 !host_out)
      else $error("host byte framing wrong");
   host_gap_a: assert property ($fell(host_oe_n) |-> idle_q >= 16'h00BE)
      else $error("host started without idle gap");
   frame_len_a: assert property ($rose(host_oe_n) |->
      hdrv_q inside {[16'h027C:16'h0284], [16'h04FC:16'h0504]}) else $error("frame length wrong");
   reply_len_a: assert property ($rose(dev_oe_n) |-> ddrv_q inside {[16'h0530:16'h0550]})
      else $error("reply length wrong");
   dev_tail_a: assert property ($rose(dev_oe_n) |-> dhigh_q >= 16'h0048)
      else $error("reply not released high");
   reply_delay_a: assert property ($fell(dev_oe_n) |-> rel_q inside {[16'h006E:16'h0082]})
      else $error("reply delay wrong");

   cover property ($rose(host_oe_n) && hdrv_q > 16'h0400);
   cover property ($rose(host_oe_n) && hdrv_q < 16'h0400);
   cover property ($rose(dev_oe_n));
endmodule
`default_nettype wire

// ===== single_wire_uart_slave_tb.sv
// Self-checking bench: host and device ends joined on one line
`timescale 1ns/10ps
`default_nettype none
module single_wire_uart_slave_tb;
   logic        clock = 1'b0;
   logic        resetn;
   logic        cmd_valid, cmd_write, cmd_ready, rsp_valid, rsp_err;
   logic [7:0]  cmd_slave, node_address_setting, datagram_count, own, e_cnt;
   logic [6:0]  cmd_reg, wr_addr, rd_addr, wr_a, rd_a;
   logic [31:0] cmd_data, rsp_data, rd_data, wr_data, wr_d, r, seed;
   logic        address_increment_pin, wr_valid, rd_req;
   logic [3:0]  reply_delay_setting;
   logic [31:0] n_wr = 32'h0, n_rd = 32'h0, e_wr, e_rd;
   int          n_fail = 0, n_tests = 0, cycles = 0;

   swu_link_if link ();
   swu_host #(.CLKS_PER_BIT(16'h0010)) swu_host_inst (.clock(clock), .resetn(resetn),
      .link(link), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_slave(cmd_slave),
      .cmd_reg(cmd_reg), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_err(rsp_err), .rsp_data(rsp_data));
   swu_device swu_device_inst (.clock(clock), .resetn(resetn), .link(link),
      .node_address_setting(node_address_setting), .address_increment_pin(address_increment_pin),
      .reply_delay_setting(reply_delay_setting), .rd_data(rd_data), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
      .datagram_count(datagram_count));
   swu_link_asserts swu_link_asserts_inst (.clock(clock), .resetn(resetn),
      .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n), .host_out(link.host_out),
      .host_oe_n(link.host_oe_n), .line(link.line));

   always #10 clock = ~clock;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Device strobes captured as they pass
   always @(posedge clock) begin
      cycles++;
      if (wr_valid === 1'b1) begin
         n_wr <= n_wr + 1;
         wr_a <= wr_addr;
         wr_d <= wr_data;
      end
      if (rd_req === 1'b1) begin
         n_rd <= n_rd + 1;
         rd_a <= rd_addr;
      end
      if (cycles == 99000) begin
         n_fail++;
         finish_test();
      end
   end

   task automatic run(input logic w, input logic [7:0] s, input logic [6:0] g,
                      input logic [31:0] d, input logic [31:0] rv);
      int k;
      logic hit;
      hit = (s == own);
      @(posedge clock);
      while (cmd_ready !== 1'b1) @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_slave <= s;
      cmd_reg   <= g;
      cmd_data  <= d;
      rd_data   <= rv;
      @(posedge clock);
      cmd_valid <= 1'b0;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 8000) begin
         @(posedge clock);
         k++;
      end
      chk({31'h0, rsp_valid}, 32'h1);
      e_wr = e_wr + {31'h0, w & hit};
      e_rd = e_rd + {31'h0, !w & hit};
      e_cnt = e_cnt + {7'h00, w & hit};
      chk(n_wr, e_wr);
      chk(n_rd, e_rd);
      chk({24'h0, datagram_count}, {24'h0, e_cnt});
      if (w && hit) begin
         chk({25'h0, wr_a}, {25'h0, g});
         chk(wr_d, d);
      end
      if (!w) begin
         chk({31'h0, rsp_err}, {31'h0, !hit});
         if (hit) chk(rsp_data, rv);
         if (hit) chk({25'h0, rd_a}, {25'h0, g});
      end
   endtask

   initial begin
      seed = 32'h76DB;
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_slave = 8'h00;
      cmd_reg = 7'h00;
      cmd_data = 32'h0;
      rd_data = 32'h0;
      node_address_setting = 8'h00;
      address_increment_pin = 1'b0;
      reply_delay_setting = 4'h0;
      e_wr = 32'h0;
      e_rd = 32'h0;
      e_cnt = 8'h00;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         r = xs();
         if (i < 2) r[16:8] = 9'h1FF; // Increment wraps the address to zero
         if (r[15:8] + {7'h00, r[16]} == 8'hFF) r[16] = ~r[16];
         node_address_setting <= r[15:8];
         address_increment_pin <= r[16];
         reply_delay_setting <= {3'h0, r[17]};
         own = r[15:8] + {7'h00, r[16]};
         repeat (4) @(posedge clock);
         run(i == 0 ? 1'b1 : r[20], r[19:18] == 2'h0 ? own + 8'h01 : own,
             i < 2 ? 7'h7F : r[27:21], i == 0 ? 32'hFFFFFFFF : xs(), xs());
      end
      finish_test();
   end
endmodule
`default_nettype wire
